/* File: core/gfog_cfg.svh */
// Constants for the glitch-free output gate.
// Assumes inclusion by the package and the gate module only.
`ifndef GFOG_CFG_SVH
`define GFOG_CFG_SVH

// -----------------------------------------------------------------
// Sizes and timing
// -----------------------------------------------------------------
`define GFOG_NUM_OUT        10
`define GFOG_MAX_EN_CYCLES  2
`define GFOG_CLK_PERIOD_NS  8

`endif

/* File: core/gfog_pkg.sv */
// Types for the glitch-free output gate.
// Assumes gfog_cfg.svh is on the include path.
`include "gfog_cfg.svh"

package gfog_pkg;

    // -------------------------------------------------------------
    // Gate states, one-hot
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        GFOG_HIZ   = 3'h1,
        GFOG_LOW   = 3'h2,
        GFOG_RUN   = 3'h4
    } gfog_state_e;

    typedef struct packed {
        logic        en_s1;
        logic        en_s2;
        gfog_state_e state;
        logic [1:0]  low_cnt;
        logic        drive;
        logic        gate;
    } gfog_reg_s;

    typedef struct packed {
        logic [`GFOG_NUM_OUT-1:0] val;
        logic [`GFOG_NUM_OUT-1:0] oe;
    } gfog_out_s;

endpackage

/* File: core/gfog_gate.sv */
// Output gating of a ten-output clock fanout: enable, hold low, tristate.
// Assumes clk is the sampling clock at 125 MHz and ref_clk is the selected
// input clock, sampled here as an ordinary pin.
`timescale 1ns/1ns
`default_nettype none
`include "gfog_cfg.svh"

// Operation
// [R1] Enable low: outputs go high impedance at the next falling input edge.
// [R2] Outputs stay high impedance while enable stays low.
// [R3] Enable high from high impedance drives all outputs low at once.
// [R4] Toggling resumes within two input cycles, only after a falling edge.
// [R5] With static input clock, enable rising still drives outputs low.
// [R6] With static input clock, enable falling waits for a later falling edge.
// [R7] Enabled and resumed, every output copies the selected input clock.
module gfog_gate
    import gfog_pkg::*;
#(
    parameter int NUM_OUT = `GFOG_NUM_OUT
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic               ref_clk,
    input  wire logic               out_en,
    output var  logic [NUM_OUT-1:0] clk_out,
    output var  logic [NUM_OUT-1:0] clk_out_oe
);

    // -------------------------------------------------------------
    // Synchroniser and state registers
    // -------------------------------------------------------------
    logic      ref_s1_r;
    logic      ref_s2_r;
    logic      ref_s3_r;
    logic      ref_s1_nxt;
    logic      ref_s2_nxt;
    logic      ref_s3_nxt;
    logic      ref_fall;
    logic      en_sync;
    gfog_reg_s q_r;
    gfog_reg_s q_nxt;

    // -------------------------------------------------------------
    // Input clock sampling
    // -------------------------------------------------------------
    // S1 may go metastable; only s2 and the s3 tap behind it feed logic.
    // Limitation: the input clock must stay well below half of clk.
    always_comb begin
        ref_s1_nxt = ref_clk;
        ref_s2_nxt = ref_s1_r;
        ref_s3_nxt = ref_s2_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end else if (clk_en) begin
            ref_s1_r <= ref_s1_nxt;
            ref_s2_r <= ref_s2_nxt;
            ref_s3_r <= ref_s3_nxt;
        end
    end

    // Reset low, so a high static input after reset reads as a rise
    assign ref_fall = ref_s3_r & ~ref_s2_r;
    assign en_sync  = q_r.en_s2;

    // -------------------------------------------------------------
    // Gate state machine
    // -------------------------------------------------------------
    always_comb begin
        q_nxt         = q_r;
        q_nxt.en_s1   = out_en;
        q_nxt.en_s2   = q_r.en_s1;
        q_nxt.low_cnt = 2'h0;
        // Next state
        case (q_r.state)
            GFOG_HIZ: begin
                // No input edge is needed to leave tristate
                if (en_sync) begin // [R3] [R5]
                    q_nxt.state = GFOG_LOW;
                end else begin // [R2]
                    q_nxt.state = GFOG_HIZ;
                end
            end
            GFOG_LOW: begin
                // Held low until a falling edge, so no runt first pulse
                if (ref_fall && !en_sync) begin // [R1] [R6]
                    q_nxt.state = GFOG_HIZ;
                end else if (ref_fall) begin // [R4]
                    q_nxt.state = GFOG_RUN;
                end else begin
                    q_nxt.state = GFOG_LOW;
                end
            end
            GFOG_RUN: begin
                // Leave only on a falling edge; outputs still high there drop low on the same clk edge as tristate
                if (ref_fall && !en_sync) begin // [R1] [R6]
                    q_nxt.state = GFOG_HIZ;
                end else begin // [R7]
                    q_nxt.state = GFOG_RUN;
                end
            end
            default: begin
                q_nxt.state = GFOG_HIZ;
            end
        endcase
        // Drive and gate follow the next state, so they switch on one edge
        case (q_nxt.state)
            GFOG_HIZ: begin // [R2]
                q_nxt.drive = 1'b0;
                q_nxt.gate  = 1'b0;
            end
            GFOG_LOW: begin // [R3]
                q_nxt.drive = 1'b1;
                q_nxt.gate  = 1'b0;
            end
            GFOG_RUN: begin // [R7]
                q_nxt.drive = 1'b1;
                q_nxt.gate  = 1'b1;
            end
            default: begin
                q_nxt.drive = 1'b0;
                q_nxt.gate  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r.en_s1   <= 1'b0;
            q_r.en_s2   <= 1'b0;
            q_r.state   <= GFOG_HIZ;
            q_r.low_cnt <= 2'h0;
            q_r.drive   <= 1'b0;
            q_r.gate    <= 1'b0;
        end else if (clk_en) begin
            q_r <= q_nxt; // [R2]
        end
    end

    // -------------------------------------------------------------
    // Output fan-out, all from flip-flops
    // -------------------------------------------------------------
    // Outputs take the next state, so they are not a cycle behind it
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        logic val_nxt;
        logic oe_nxt;

        always_comb begin
            val_nxt = q_nxt.gate & ref_s2_r; // [R7]
            oe_nxt  = q_nxt.drive; // [R2] [R3]
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                clk_out[i]    <= 1'b0;
                clk_out_oe[i] <= 1'b0;
            end else if (clk_en) begin
                clk_out[i]    <= val_nxt;
                clk_out_oe[i] <= oe_nxt;
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/gfog_checker.sv */
// Port checker for the output gate.
// Assumes a ref half period of 4 clk and binding from the bench top.
`timescale 1ns/1ns
`default_nettype none
module gfog_checker #(parameter int NUM_OUT = 10) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               clk_en,
    input wire logic               ref_clk,
    input wire logic               out_en,
    input wire logic [NUM_OUT-1:0] clk_out,
    input wire logic [NUM_OUT-1:0] clk_out_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_en_drive: assert property ($rose(out_en) && clk_out_oe == 0 |-> ##3
        (&clk_out_oe && clk_out == 0)) else $error("enable not driven low");
    a_hiz_hold: assert property (!out_en && clk_out_oe == 0 |=> clk_out_oe == 0)
        else $error("left high impedance");
    a_dis_ref: assert property ($fell(clk_out_oe[0]) |->
        $past(ref_clk, 5) && !$past(ref_clk, 2)) else $error("disable without ref fall");
    a_dis_low: assert property ($fell(clk_out_oe[0]) |-> clk_out == 0 && !$past(out_en, 3))
        else $error("disable not clean");
    a_no_runt: assert property ($rose(clk_out[0]) |=> clk_out[0][*3])
        else $error("short pulse");
    a_all_same: assert property (clk_out_oe[0] |-> &clk_out_oe &&
        (clk_out == 0 || &clk_out)) else $error("outputs differ");
    c_en: cover property ($rose(clk_out_oe[0]));
    c_dis: cover property ($fell(clk_out_oe[0]));
    c_run: cover property ($rose(clk_out[0]));
endmodule
`default_nettype wire

/* File: tb/gfog_ref.sv */
// Selected input clock source, 8 clk period while running.
// Assumes run changes off the clk edge; level holds while stopped.
`timescale 1ns/1ns
`default_nettype none
module gfog_ref (
    input  wire logic clk,
    input  wire logic run,
    output var  logic ref_clk
);
    logic [1:0] cnt = 2'h0;
    initial ref_clk = 1'b1;
    always @(posedge clk) if (run) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) ref_clk <= #1 ~ref_clk;
    end
endmodule
`default_nettype wire

/* File: tb/test_glitch_free_output_gate.sv */
// Self-checking bench for the output gate.
// Assumes gfog_ref as input clock source and gfog_checker bound below.
`timescale 1ns/1ns
`default_nettype none
module test_glitch_free_output_gate;
    logic       clk = 0, rst_n = 0, out_en = 0, run = 0, ref_clk;
    logic [9:0] clk_out, clk_out_oe, oe_seen = 10'h0;
    logic [9:0] exp_q[$];
    int         miscompares = 0, check_count = 0, cyc = 0, i, seed = 32'h7aba;
    gfog_ref gfog_ref_i (.clk(clk), .run(run), .ref_clk(ref_clk));
    gfog_gate gfog_gate_i (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .ref_clk(ref_clk),
        .out_en(out_en), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
    initial forever #4 clk = ~clk;
    task automatic chk(string n, logic [9:0] e, logic [9:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        if (exp_q.size() != 0) miscompares++;
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc_wait(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_en(logic v);
        out_en = v;
        exp_q.push_back({10{v}});
    endtask
    // Outputs watcher; an unexpected change can never match
    always @(posedge clk) begin
        #2;
        cyc++;
        if (cyc > 4000) begin
            miscompares++;
            finish_test();
        end
        if (clk_out_oe !== oe_seen) begin
            oe_seen = clk_out_oe;
            chk("oe", exp_q.size() ? exp_q.pop_front() : ~clk_out_oe, clk_out_oe);
            chk("low", 10'h0, clk_out);
        end
    end
    initial begin
        cyc_wait(5);
        rst_n = 1;
        cyc_wait(2);
        set_en(1);
        cyc_wait(8);
        out_en = 0;
        cyc_wait(20);
        chk("static", 10'h3ff, clk_out_oe);
        exp_q.push_back(10'h0);
        run = 1;
        cyc_wait(20);
        repeat (6) begin
            set_en(!out_en);
            cyc_wait(4);
            for (i = 0; i < 20 && out_en && clk_out[0] !== 1'b1; i++) cyc_wait(1);
            if (out_en) chk("resume", 10'h3ff, clk_out);
            cyc_wait(20 + {$random(seed)} % 16);
        end
        finish_test();
    end
endmodule
bind gfog_gate gfog_checker #(.NUM_OUT(NUM_OUT)) gfog_checker_i (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .ref_clk(ref_clk), .out_en(out_en), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe));
`default_nettype wire
